// file: shared/crcce_pkg.sv
// crcce_pkg: shared constants and types of the crc checksum engine
package crcce_pkg;
    // register byte offsets
    localparam logic [7:0] CRCCE_OFS_MODE = 8'h00;
    localparam logic [7:0] CRCCE_OFS_SEED = 8'h04;
    localparam logic [7:0] CRCCE_OFS_SUM = 8'h08;
    localparam logic [7:0] CRCCE_OFS_DATA = 8'h0C;
    localparam logic [7:0] CRCCE_OFS_STAT = 8'h10;
    // mode register field positions
    localparam int CRCCE_MODE_POLY_LSB = 0;
    localparam int CRCCE_MODE_IN_REV = 2;
    localparam int CRCCE_MODE_IN_CMP = 3;
    localparam int CRCCE_MODE_OUT_REV = 4;
    localparam int CRCCE_MODE_OUT_CMP = 5;
    // status register field positions
    localparam int CRCCE_STAT_BUSY = 0;
    localparam int CRCCE_STAT_LVL_LSB = 1;
    // reset values
    localparam logic [5:0] CRCCE_MODE_RST = 6'h00;
    localparam logic [31:0] CRCCE_SEED_RST = 32'h0000_0000;
    // polynomial select codes
    localparam logic [1:0] CRCCE_POLY_CCITT = 2'h0;
    localparam logic [1:0] CRCCE_POLY_C16 = 2'h1;
    localparam logic [1:0] CRCCE_POLY_C32 = 2'h2;
    // generator polynomials, top term implied
    localparam logic [31:0] CRCCE_GEN_CCITT = 32'h0000_1021;
    localparam logic [31:0] CRCCE_GEN_C16 = 32'h0000_8005;
    localparam logic [31:0] CRCCE_GEN_C32 = 32'h04C1_1DB7;
    // data write width codes
    localparam logic [1:0] CRCCE_SZ_8 = 2'h0;
    localparam logic [1:0] CRCCE_SZ_16 = 2'h1;
    localparam logic [1:0] CRCCE_SZ_32 = 2'h2;
    // fifo defaults
    localparam int CRCCE_FIFO_DEPTH = 8;
    // one queued data write: width code and data
    typedef struct packed {
        logic [1:0] size;
        logic [31:0] data;
    } crcce_word_t;
    // mode settings
    typedef struct packed {
        logic out_cmp;
        logic out_rev;
        logic in_cmp;
        logic in_rev;
        logic [1:0] poly;
    } crcce_mode_t;
    // register port request
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [1:0] size;
        logic [31:0] wdata;
    } crcce_req_t;
endpackage

// file: logic/crcce_engine.sv
// crcce_engine: crc checksum engine with its input fifo
//
// Function
// RQ1: three polynomials: CCITT, CRC-16, CRC-32 selectable
// RQ2: optional bit reversal and complement of input
// RQ3: optional bit reversal and complement of sum
// RQ4: software seed loads the accumulator
// RQ5: back-to-back writes from CPU or DMA absorbed
// RQ6: 8, 16 or 32-bit writes, written lanes only
// RQ7: byte write folds in one cycle
// RQ8: halfword write takes two byte cycles
// RQ9: word write takes four byte cycles
// RQ10: new writes held off until bytes done; data_ready drops only while the fifo is full
// RQ11: sum read returns value, accumulator unchanged
`timescale 1ns/1ps

module crcce_fifo #(
    parameter int WIDTH = 34,
    parameter int DEPTH = 8
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // filling side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // draining side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    // fill level
    output logic [$clog2(DEPTH):0] level
);
    localparam int AW = $clog2(DEPTH);

    // pointers wrap by hand, so any depth of 2 or more works
    generate
        if (DEPTH < 2) begin : g_chk
            $error("crcce_fifo: DEPTH must be at least 2");
        end
    endgenerate

    logic [WIDTH-1:0] mem_r [DEPTH];  // storage
    logic [AW-1:0] wp_r, wp_nxt;      // write index
    logic [AW-1:0] rp_r, rp_nxt;      // read index
    logic [AW:0] cnt_r, cnt_nxt;      // stored words
    logic push, pop;

    // honest flags straight from the count
    assign in_ready = (cnt_r != (AW+1)'(DEPTH)) ? 1'b1 : 1'b0;
    assign out_valid = (cnt_r != '0);
    assign out_data = mem_r[rp_r];
    assign level = cnt_r;
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    // next pointers and count
    always_comb begin
        wp_nxt = wp_r;
        rp_nxt = rp_r;
        cnt_nxt = cnt_r;
        if (push) begin
            wp_nxt = (wp_r == AW'(DEPTH - 1)) ? '0 : wp_r + 1'b1;
        end
        if (pop) begin
            rp_nxt = (rp_r == AW'(DEPTH - 1)) ? '0 : rp_r + 1'b1;
        end
        case ({push, pop})
            2'b10: cnt_nxt = cnt_r + 1'b1;
            2'b01: cnt_nxt = cnt_r - 1'b1;
            default: cnt_nxt = cnt_r;
        endcase
    end

    // pointer registers
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
        end else begin
            wp_r <= wp_nxt;
            rp_r <= rp_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    // storage needs no reset; only written slots are ever read
    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem_r[wp_r] <= in_data;
        end
    end
endmodule

module crcce_engine #(
    parameter int FIFO_DEPTH = crcce_pkg::CRCCE_FIFO_DEPTH
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // register port
    input wire crcce_pkg::crcce_req_t req,
    output logic [31:0] rdata,
    // data port may take a write this cycle
    output logic data_ready
);
    import crcce_pkg::*;

    localparam int LW = $clog2(FIFO_DEPTH) + 1;

    generate
        if (LW > 31 - CRCCE_STAT_LVL_LSB) begin : g_chk
            $error("crcce_engine: FIFO_DEPTH too large for status");
        end
    endgenerate

    typedef enum logic [0:0] {
        CRCCE_IDLE = 1'b0,  // no word in hand
        CRCCE_STEP = 1'b1   // folding bytes of a word
    } crcce_state_t;

    // one byte of msb-first crc; 16-bit sums live in the low half
    function automatic logic [31:0] crcce_fold(
        input logic [31:0] acc,
        input logic [7:0] din,
        input logic [1:0] poly
    );
        logic [31:0] c;
        logic [31:0] gen;
        logic fb;
        c = acc;
        case (poly)
            CRCCE_POLY_C16: gen = CRCCE_GEN_C16;
            CRCCE_POLY_C32: gen = CRCCE_GEN_C32;
            default: gen = CRCCE_GEN_CCITT;
        endcase
        for (int i = 7; i >= 0; i--) begin
            if (poly == CRCCE_POLY_C32) begin
                fb = c[31] ^ din[i];
                c = {c[30:0], 1'b0};
            end else begin
                fb = c[15] ^ din[i];
                c = {16'h0000, c[14:0], 1'b0};
            end
            if (fb) begin
                c = c ^ gen;
            end
        end
        return c;
    endfunction

    // reverse the low n bits, clearing the rest
    function automatic logic [31:0] crcce_rev(
        input logic [31:0] v,
        input logic wide
    );
        logic [31:0] r;
        r = '0;
        for (int i = 0; i < 32; i++) begin
            r[31-i] = v[i];
        end
        return wide ? r : {16'h0000, r[31:16]};
    endfunction

    crcce_mode_t mode_r, mode_nxt;     // mode register
    logic [31:0] acc_r, acc_nxt;       // checksum accumulator
    crcce_state_t st_r, st_nxt;        // byte stepper state
    crcce_word_t word_r, word_nxt;     // word being folded
    logic [1:0] idx_r, idx_nxt;        // byte in progress
    logic [31:0] rdata_r, rdata_nxt;   // read answer
    logic wr_mode, wr_seed, wr_data;
    logic q_valid, q_ready, last_step;
    crcce_word_t q_word;
    logic [LW-1:0] q_level;
    logic wide;
    logic [7:0] in_byte;
    logic [31:0] sum_view;

    // register decode
    assign wr_mode = req.wr & (req.addr == CRCCE_OFS_MODE);
    assign wr_seed = req.wr & (req.addr == CRCCE_OFS_SEED);
    assign wr_data = req.wr & (req.addr == CRCCE_OFS_DATA);
    assign wide = (mode_r.poly == CRCCE_POLY_C32);

    // writes queue so dma bursts need no wait states until the fifo fills
    crcce_fifo #(
        .WIDTH($bits(crcce_word_t)),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .ref_clk(ref_clk),
        .rst(rst),
        .in_valid(wr_data),  // RQ5
        .in_ready(data_ready),  // RQ10
        .in_data({req.size, req.wdata}),
        .out_valid(q_valid),
        .out_ready(q_ready),
        .out_data(q_word),
        .level(q_level)
    );

    // last byte lane of the word in hand, per its width
    always_comb begin
        case (word_r.size)
            CRCCE_SZ_16: last_step = (idx_r == 2'h1);  // RQ8
            CRCCE_SZ_32: last_step = (idx_r == 2'h3);  // RQ9
            default: last_step = 1'b1;  // RQ7
        endcase
    end

    // take a new word when idle or on the last byte of the current one
    assign q_ready = (st_r == CRCCE_IDLE) | last_step;

    // input byte conditioning: lanes fold low byte first
    always_comb begin
        in_byte = word_r.data[idx_r*8 +: 8];  // RQ6
        if (mode_r.in_rev) begin
            in_byte = {in_byte[0], in_byte[1], in_byte[2], in_byte[3],
                       in_byte[4], in_byte[5], in_byte[6], in_byte[7]};
        end  // RQ2
        if (mode_r.in_cmp) begin
            in_byte = ~in_byte;  // RQ2
        end
    end

    // byte stepper and accumulator
    always_comb begin
        st_nxt = st_r;
        word_nxt = word_r;
        idx_nxt = idx_r;
        acc_nxt = acc_r;
        mode_nxt = mode_r;
        if (wr_mode) begin
            mode_nxt = crcce_mode_t'(req.wdata[5:0]);  // RQ1
        end
        if (st_r == CRCCE_STEP) begin
            acc_nxt = crcce_fold(acc_r, in_byte, mode_r.poly);  // RQ7
            idx_nxt = idx_r + 2'h1;
        end
        if (q_ready) begin
            if (q_valid) begin
                st_nxt = CRCCE_STEP;
                word_nxt = q_word;
                idx_nxt = 2'h0;
            end else begin
                st_nxt = CRCCE_IDLE;
            end
        end
        // a seed write wins over a byte folding in the same cycle
        if (wr_seed) begin
            acc_nxt = wide ? req.wdata : {16'h0000, req.wdata[15:0]};  // RQ4
        end
    end

    // checksum as the reader sees it; accumulator left alone
    always_comb begin
        sum_view = acc_r;
        if (mode_r.out_rev) begin
            sum_view = crcce_rev(acc_r, wide);  // RQ3
        end
        if (mode_r.out_cmp) begin
            sum_view = sum_view ^ (wide ? 32'hFFFF_FFFF : 32'h0000_FFFF);
        end  // RQ3
    end

    // read mux, answer stands only in the cycle after the strobe
    always_comb begin
        rdata_nxt = '0;
        if (req.rd) begin
            case (req.addr)
                CRCCE_OFS_MODE: rdata_nxt = {26'h0, mode_r};
                CRCCE_OFS_SEED: rdata_nxt = sum_view;
                CRCCE_OFS_SUM: rdata_nxt = sum_view;  // RQ11
                CRCCE_OFS_STAT: begin
                    rdata_nxt[CRCCE_STAT_BUSY] = (st_r == CRCCE_STEP) | q_valid;
                    rdata_nxt[CRCCE_STAT_LVL_LSB +: LW] = q_level;
                end
                default: rdata_nxt = '0;
            endcase
        end
    end
    assign rdata = rdata_r;

    // state registers
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            st_r <= CRCCE_IDLE;
            word_r <= '0;
            idx_r <= 2'h0;
            acc_r <= CRCCE_SEED_RST;
            mode_r <= crcce_mode_t'(CRCCE_MODE_RST);
            rdata_r <= '0;
        end else begin
            st_r <= st_nxt;
            word_r <= word_nxt;
            idx_r <= idx_nxt;
            acc_r <= acc_nxt;
            mode_r <= mode_nxt;
            rdata_r <= rdata_nxt;
        end
    end
endmodule

// file: tb/crcce_engine_sva.sv
// port assertions of the crc engine
`timescale 1ns/1ps
module crcce_engine_sva (
    // clock, reset
    input wire logic ref_clk,
    input wire logic rst,
    // register port
    input wire crcce_pkg::crcce_req_t req,
    input wire logic [31:0] rdata,
    input wire logic data_ready
);
    import crcce_pkg::*;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    // status read, mode write and mode read strobes
    wire logic st = req.rd && req.addr == CRCCE_OFS_STAT;
    wire logic mw = req.wr && req.addr == CRCCE_OFS_MODE;
    wire logic mr = req.rd && req.addr == CRCCE_OFS_MODE;
    // idle engine seen, then a data write of width z
    sequence s_go(logic [1:0] z);
        st ##1 (rdata == 32'h0 && !req.wr) ##1
        (req.wr && req.addr == CRCCE_OFS_DATA && req.size == z);
    endsequence
    property p_quiet; !req.rd |=> rdata == 32'h0; endproperty
    a_quiet: assert property (p_quiet)
        else $error("rdata not idle");
    property p_mode;
        mw ##1 mr |=> rdata == {26'h0, $past(req.wdata[5:0], 2)};
    endproperty
    a_mode: assert property (p_mode)
        else $error("mode readback");
    property p_unmap;
        req.rd && req.addr > CRCCE_OFS_STAT |=> rdata == 32'h0;
    endproperty
    a_unmap: assert property (p_unmap)
        else $error("unmapped read");
    // one word leaves the fifo within four byte steps
    property p_room; $fell(data_ready) |-> ##[1:5] data_ready; endproperty
    a_room: assert property (p_room)
        else $error("fifo stuck full");
    // the queue stage adds one cycle before the first byte step
    property p_byte;
        s_go(CRCCE_SZ_8) ##1 !req.wr [*2] ##1 st |=> !rdata[0];
    endproperty
    a_byte: assert property (p_byte)
        else $error("byte too slow");
    property p_half;
        s_go(CRCCE_SZ_16) ##1 !req.wr [*3] ##1 st |=> !rdata[0];
    endproperty
    a_half: assert property (p_half)
        else $error("halfword too slow");
    property p_busy;
        s_go(CRCCE_SZ_32) ##1 !req.wr [*4] ##1 st |=> rdata[0];
    endproperty
    a_busy: assert property (p_busy)
        else $error("word too fast");
    property p_word;
        s_go(CRCCE_SZ_32) ##1 !req.wr [*5] ##1 st |=> !rdata[0];
    endproperty
    a_word: assert property (p_word)
        else $error("word too slow");
    c_word: cover property (s_go(CRCCE_SZ_32));
    c_full: cover property ($fell(data_ready));
    c_mode: cover property (mw ##1 mr);
endmodule
bind crcce_engine crcce_engine_sva u_sva (.ref_clk(ref_clk), .rst(rst),
    .req(req), .rdata(rdata), .data_ready(data_ready));

// file: tb/crcce_host.sv
// bus master model feeding the crc engine
`timescale 1ns/1ps
module crcce_host (
    // clock
    input wire logic ref_clk,
    // register port
    output crcce_pkg::crcce_req_t req,
    input wire logic [31:0] rdata,
    input wire logic data_ready
);
    import crcce_pkg::*;
    logic last_ok; // engine had room for the last write
    initial req = '0;
    // strobe stays up so writes may run back to back
    task automatic wr(logic [7:0] a, logic [1:0] s, logic [31:0] d);
        req <= '{1'b1, 1'b0, a, s, d};
        @(negedge ref_clk);
        last_ok = data_ready;
        @(posedge ref_clk);
    endtask
    // one quiet cycle
    task automatic idle();
        req <= '0;
        @(posedge ref_clk);
    endtask
    // data stands only in the cycle after the strobe
    task automatic rd(logic [7:0] a, output logic [31:0] d);
        req <= '{1'b0, 1'b1, a, 2'h0, 32'h0};
        @(posedge ref_clk);
        req <= '0;
        @(negedge ref_clk);
        d = rdata;
        @(posedge ref_clk);
    endtask
endmodule

// file: tb/crcce_engine_test.sv
// self-checking bench of the crc engine
`timescale 1ns/1ps
module crcce_engine_test;
    import crcce_pkg::*;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    crcce_req_t req;
    logic [31:0] rdata;
    logic data_ready;
    logic [5:0] md; // model mode; bit 1 marks the 32-bit poly
    logic [31:0] acc; // model accumulator
    logic [31:0] got;
    int n_mismatch = 0;
    int total_checks = 0;
    int taken = 0;
    logic [5:0] modes [6] = '{6'h00, 6'h01, 6'h02, 6'h3E, 6'h24, 6'h19};
    always #5 ref_clk = ~ref_clk;
    crcce_engine uut (.ref_clk(ref_clk), .rst(rst), .req(req),
        .rdata(rdata), .data_ready(data_ready));
    crcce_host host (.ref_clk(ref_clk), .req(req), .rdata(rdata),
        .data_ready(data_ready));
    // one msb-first byte step
    function automatic logic [31:0] fold(logic [31:0] a, logic [7:0] b);
        logic [31:0] g;
        logic t;
        logic [7:0] v;
        g = md[1] ? CRCCE_GEN_C32 : md[0] ? CRCCE_GEN_C16 : CRCCE_GEN_CCITT;
        if (md[3]) b = ~b;
        v = b;
        for (int i = 0; i < 8; i++) begin
            if (md[2]) b[i] = v[7 - i];
        end
        for (int i = 7; i >= 0; i--) begin
            t = (md[1] ? a[31] : a[15]) ^ b[i];
            a = {a[30:0], 1'b0} ^ (t ? g : 32'h0);
        end
        return md[1] ? a : {16'h0, a[15:0]};
    endfunction
    // reader's view of the sum
    function automatic logic [31:0] view(logic [31:0] a);
        logic [31:0] r;
        for (int i = 0; i < 32; i++) begin
            r[i] = a[31 - i];
        end
        if (md[4]) a = md[1] ? r : r >> 16;
        if (md[5]) a = ~a;
        return md[1] ? a : {16'h0, a[15:0]};
    endfunction
    task automatic chk(string nm, logic [31:0] e, logic [31:0] s);
        total_checks++;
        if (s !== e) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic rdc(logic [7:0] a, logic [31:0] e, string nm);
        host.rd(a, got);
        chk(nm, e, got);
    endtask
    // refused words are left out of the model
    task automatic feed(logic [1:0] s, logic [31:0] d);
        host.wr(CRCCE_OFS_DATA, s, d);
        if (host.last_ok === 1'b1) begin
            taken++;
            for (int i = 0; i < (1 << s); i++) begin
                acc = fold(acc, d[8*i +: 8]);
            end
        end
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // bounded poll until idle
    task automatic settle();
        for (int i = 0; i < 40; i++) begin
            host.rd(CRCCE_OFS_STAT, got);
            if (got === 32'h0) return;
        end
        n_mismatch++;
        complete_run();
    endtask
    task automatic seed(logic [31:0] v);
        host.wr(CRCCE_OFS_SEED, CRCCE_SZ_32, v);
        acc = md[1] ? v : {16'h0, v[15:0]};
    endtask
    initial begin
        repeat (10) @(posedge ref_clk);
        rst <= 1'b0;
        md = 6'h00;
        chk("ready", 32'h1, {31'h0, data_ready});
        rdc(CRCCE_OFS_MODE, 32'h0, "mode");
        rdc(CRCCE_OFS_SUM, 32'h0, "sum");
        rdc(8'h20, 32'h0, "unmapped");
        rdc(CRCCE_OFS_STAT, 32'h0, "stat");
        $display("reset test done");
        foreach (modes[k]) begin
            md = modes[k];
            host.wr(CRCCE_OFS_MODE, CRCCE_SZ_32, {26'h0, md});
            rdc(CRCCE_OFS_MODE, {26'h0, md}, "mode");
            seed(32'hC3A5_0F96);
            feed(CRCCE_SZ_32, 32'h1234_5678);
            feed(CRCCE_SZ_16, 32'hDEAD_BEEF);
            feed(CRCCE_SZ_8, 32'h7755_33A1);
            settle();
            rdc(CRCCE_OFS_SUM, view(acc), "sum");
            rdc(CRCCE_OFS_SUM, view(acc), "sum");
            rdc(CRCCE_OFS_SEED, view(acc), "seed read");
            $display("mode %h test done", md);
        end
        // busy spans the queue stage and n byte steps, then clears
        md = 6'h02;
        host.wr(CRCCE_OFS_MODE, CRCCE_SZ_32, 32'h2);
        seed(32'h0);
        for (int n = 1; n <= 4; n *= 2) begin
            for (int g = 0; g <= n + 1; g++) begin
                settle();
                feed(2'(n >> 1), 32'hA5C3_9E17);
                repeat (g) host.idle();
                host.rd(CRCCE_OFS_STAT, got);
                chk("busy", 32'(g <= n), {31'h0, got[0]});
            end
        end
        settle();
        rdc(CRCCE_OFS_SUM, view(acc), "sum");
        $display("timing test done");
        // burst 16 word writes so the fifo refuses some, then drain
        taken = 0;
        for (int i = 0; i < 16; i++) begin
            feed(CRCCE_SZ_32, {4{8'(i)}});
        end
        chk("refused", 32'h1, {31'h0, 1'(taken < 16)});
        settle();
        rdc(CRCCE_OFS_SUM, view(acc), "burst sum");
        $display("burst test done");
        complete_run();
    end
endmodule
